// ===== core/sar_adc_parallel_control_port.sv
`timescale 1ns/1ps
module sar_adc_parallel_control_port #(
  parameter int RES_W = 12
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              cs_n_in,
  input  wire logic              wr_n_in,
  input  wire logic              rd_n_in,
  input  wire logic              upper_byte_sel_in,
  input  wire logic              ext_conv_clk_in,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_out,
  input  wire logic [RES_W-1:0]  sample_code_in,
  output logic                   done_n_out,
  output logic                   track_out,
  output logic                   converting_out,
  output logic      [1:0]        power_mode_out,
  output logic                   int_clk_sel_out,
  output logic                   acquire_timing_sel_out,
  output logic                   input_config_sel_out,
  output logic                   polarity_sel_out,
  output logic      [2:0]        chan_addr_out
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (RES_W != sar_ctl_pkg::RESULT_W) begin
    $error("result width must match the converter code width");
  end
  if (sar_ctl_pkg::INT_DIV < 1 || sar_ctl_pkg::INT_DIV > 256) begin
    $error("internal clock divide ratio does not fit the divider");
  end
  if (sar_ctl_pkg::CONV_CYCLES > 15 || sar_ctl_pkg::ACQ_CYCLES > 15) begin
    $error("cycle counts do not fit the sequencer counter");
  end
  if (sar_ctl_pkg::CHAN_W != 3) begin
    $error("channel address width must be three bits");
  end

  typedef enum logic [1:0] {S_IDLE, S_TRACK, S_CONV} conv_state_t;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] cs_s_r, wr_s_r, rd_s_r, hb_s_r, ck_s_r;
  logic [7:0] d_s1_r, d_s2_r;
  // strobes reset to their idle high level so no false edge follows reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cs_s_r <= 2'h3;
    end else begin
      cs_s_r <= {cs_s_r[0], cs_n_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_s_r <= 2'h3;
    end else begin
      wr_s_r <= {wr_s_r[0], wr_n_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_s_r <= 2'h3;
    end else begin
      rd_s_r <= {rd_s_r[0], rd_n_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hb_s_r <= 2'h0;
    end else begin
      hb_s_r <= {hb_s_r[0], upper_byte_sel_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_s_r <= 2'h0;
    end else begin
      ck_s_r <= {ck_s_r[0], ext_conv_clk_in};
    end
  end

  // data lines take the same two stages as the strobes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      d_s1_r <= 8'h00;
      d_s2_r <= 8'h00;
    end else begin
      d_s1_r <= data_in;
      d_s2_r <= d_s1_r;
    end
  end

  logic cs_q, wr_q, rd_q, hb_q, ck_q;
  assign cs_q = cs_s_r[1];
  assign wr_q = wr_s_r[1];
  assign rd_q = rd_s_r[1];
  assign hb_q = hb_s_r[1];
  assign ck_q = ck_s_r[1];

  // ****************************************
  // strobe edges
  // ****************************************
  logic wr_act_r, rd_act_r, ck_prev_r;
  logic [7:0] wr_data_r;
  logic wr_act, rd_act, wr_done, rd_start, ext_fall;
  assign wr_act = ~cs_q & ~wr_q; // RULE25 RULE14
  assign rd_act = ~cs_q & ~rd_q; // RULE14
  assign wr_done  = wr_act_r & ~wr_act; // RULE25
  assign rd_start = rd_act & ~rd_act_r;
  assign ext_fall = ck_prev_r & ~ck_q & ~cs_q; // RULE14

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_act_r  <= 1'b0;
      rd_act_r  <= 1'b0;
      ck_prev_r <= 1'b0;
    end else begin
      wr_act_r  <= wr_act;
      rd_act_r  <= rd_act;
      ck_prev_r <= ck_q;
    end
  end

  // the last byte seen while the write stands is the one taken
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_data_r <= 8'h00;
    end else if (wr_act) begin
      wr_data_r <= d_s2_r; // RULE16 RULE15
    end
  end

  // ****************************************
  // control byte
  // ****************************************
  logic [7:0] ctrl_r;
  logic       int_clk_r;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= sar_ctl_pkg::CTRL_RESET;
    end else if (wr_done) begin
      ctrl_r <= wr_data_r;
    end
  end

  // power-down codes leave the clock source as it was
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_clk_r <= 1'b0; // RULE10
    end else if (wr_done) begin
      case (wr_data_r[sar_ctl_pkg::PMODE_HI_BIT -: 2])
        sar_ctl_pkg::PM_INT_CLK: int_clk_r <= 1'b1; // RULE4
        sar_ctl_pkg::PM_EXT_CLK: int_clk_r <= 1'b0; // RULE4
        default:                 int_clk_r <= int_clk_r; // RULE3 RULE9
      endcase
    end
  end

  assign power_mode_out         = ctrl_r[sar_ctl_pkg::PMODE_HI_BIT -: 2]; // RULE3
  assign int_clk_sel_out        = int_clk_r;
  assign acquire_timing_sel_out = ctrl_r[sar_ctl_pkg::ACQ_BIT]; // RULE5 RULE11
  assign input_config_sel_out   = ctrl_r[sar_ctl_pkg::CFG_BIT]; // RULE6
  assign polarity_sel_out       = ctrl_r[sar_ctl_pkg::POL_BIT]; // RULE7
  assign chan_addr_out          = ctrl_r[sar_ctl_pkg::CHAN_LSB +: sar_ctl_pkg::CHAN_W]; // RULE8

  // ****************************************
  // internal conversion clock divider
  // ****************************************
  logic [7:0] div_r;
  logic       int_tick;
  assign int_tick = (div_r == 8'(sar_ctl_pkg::INT_DIV - 1));
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || wr_done || int_tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01; // RULE12
    end
  end

  logic tick;
  assign tick = int_clk_r ? int_tick : ext_fall; // RULE11

  // ****************************************
  // acquisition and conversion sequencer
  // ****************************************
  conv_state_t st_r;
  logic [3:0]  cnt_r;
  logic        done_n_r;
  logic [11:0] result_r;
  logic        conv_last;
  logic        ext_start;
  assign conv_last = (st_r == S_CONV) && tick
                     && (cnt_r == 4'(sar_ctl_pkg::CONV_CYCLES - 1)); // RULE21
  assign ext_start = (st_r == S_TRACK) && !wr_data_r[sar_ctl_pkg::ACQ_BIT]
                     && ctrl_r[sar_ctl_pkg::ACQ_BIT];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r  <= S_IDLE;
      cnt_r <= 4'h0;
    end else if (wr_done) begin
      cnt_r <= 4'h0;
      if (ext_start) begin
        st_r <= S_CONV; // RULE24
      end else begin
        st_r <= S_TRACK; // RULE22 RULE24
      end
    end else begin
      case (st_r)
        S_IDLE: begin
          st_r <= S_IDLE;
        end
        S_TRACK: begin
          if (!ctrl_r[sar_ctl_pkg::ACQ_BIT] && tick) begin
            if (cnt_r == 4'(sar_ctl_pkg::ACQ_CYCLES)) begin
              st_r  <= S_CONV; // RULE23
              cnt_r <= 4'h0;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        S_CONV: begin
          if (conv_last) begin
            st_r  <= S_IDLE;
            cnt_r <= 4'h0;
          end else if (tick) begin
            cnt_r <= cnt_r + 4'h1; // RULE21
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // completion flag
  // ****************************************
  // a finishing conversion wins over a read that starts in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      done_n_r <= 1'b1;
    end else if (wr_done) begin
      done_n_r <= 1'b1; // RULE2
    end else if (conv_last) begin
      done_n_r <= 1'b0; // RULE1
    end else if (rd_start) begin
      done_n_r <= 1'b1; // RULE2
    end
  end

  // ****************************************
  // result register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      result_r <= 12'h000;
    end else if (conv_last && !wr_done) begin
      result_r <= sample_code_in; // RULE17
    end
  end

  assign done_n_out     = done_n_r;
  assign track_out      = (st_r == S_TRACK);
  assign converting_out = (st_r == S_CONV);

  // ****************************************
  // read-back bus
  // ****************************************
  logic [7:0] dout_r;
  logic       oe_r;
  logic [3:0] upper_fill;
  assign upper_fill = polarity_sel_out ? 4'h0 : {4{result_r[11]}}; // RULE20 RULE17

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= rd_act; // RULE14 RULE15
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dout_r <= 8'h00;
    end else if (!hb_q) begin
      dout_r <= result_r[7:0]; // RULE19
    end else begin
      dout_r <= {upper_fill, result_r[11:8]}; // RULE20
    end
  end
  assign data_out    = dout_r;
  assign data_oe_out = oe_r;
endmodule

// ===== core/sar_ctl_pkg.sv
// What this block does
// RULE1 - completion flag goes low when result ready
// RULE2 - flag released on read or new write
// RULE3 - modes 00/01 power down, clock unchanged
// RULE4 - mode 10 internal clock, 11 external
// RULE5 - bit 5 selects acquisition timing
// RULE6 - bit 4 selects single-ended or pseudo-differential
// RULE7 - bit 3 selects unipolar or bipolar
// RULE8 - low three bits address the channel
// RULE9 - power-down keeps last clock mode
// RULE10 - external clock mode after power-up
// RULE11 - acquisition and clock choices independent
// RULE12 - internal clock converts in 3.6 us
// RULE13 - host external clock 100kHz to 4.8MHz
// RULE14 - chip select high ignores inputs, bus floats
// RULE15 - one shared tri-state byte bus
// RULE16 - control byte taken from all eight lines
// RULE17 - unipolar straight binary, bipolar two's complement
// RULE18 - host holds select and read low
// RULE19 - low byte when byte select low
// RULE20 - high byte zero or sign filled
// RULE21 - conversion takes 13 clock cycles
// RULE22 - write during conversion aborts, restarts acquisition
// RULE23 - internal acquisition lasts three clock cycles; code tracks for four ticks
// RULE24 - tracking starts at write rising edge
// RULE25 - write is select and strobe low
package sar_ctl_pkg;
  // ****************************************
  // control byte fields
  // ****************************************
  localparam int PMODE_HI_BIT   = 7;
  localparam int PMODE_LO_BIT   = 6;
  localparam int ACQ_BIT        = 5;
  localparam int CFG_BIT        = 4;
  localparam int POL_BIT        = 3;
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_W         = 3;
  localparam logic [1:0] PM_SHUTDOWN = 2'h0;
  localparam logic [1:0] PM_STANDBY  = 2'h1;
  localparam logic [1:0] PM_INT_CLK  = 2'h2;
  localparam logic [1:0] PM_EXT_CLK  = 2'h3;
  localparam logic [7:0] CTRL_RESET  = 8'hC0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int CONV_CYCLES     = 13;
  localparam int ACQ_CYCLES      = 3;
  localparam int CONV_TIME_NS    = 3600;
  localparam int CLK_PERIOD_NS   = 25;
  // internal conversion clock period in system cycles, rounded down
  localparam int INT_DIV         = CONV_TIME_NS / (CONV_CYCLES * CLK_PERIOD_NS);
  localparam int RESULT_W        = 12;
endpackage

// ===== tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  input  wire logic       done_n_in,
  output logic            cs_n_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic            hbe_out,
  output logic            eclk_out,
  output logic [7:0]      d_out
);
  initial begin
    {cs_n_out, wr_n_out, rd_n_out, hbe_out, eclk_out} = 5'h1C;
    d_out = 8'h5A;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // released lines show the inverted byte, never the last value
  task automatic wr(input logic [7:0] b, input logic sel);
    {cs_n_out, wr_n_out, d_out} = {~sel, 1'b0, b};
    cyc(4);
    wr_n_out = 1'b1;
    cyc(1);
    {cs_n_out, d_out} = {1'b1, ~b};
    cyc(6);
  endtask
  task automatic rd(input logic hi, output logic [7:0] v);
    hbe_out = hi;
    cyc(6);
    {cs_n_out, rd_n_out} = 2'b00;
    cyc(5);
    v = bus_in;
    {cs_n_out, rd_n_out} = 2'b11;
    cyc(5);
  endtask
  // 4 MHz half-duty conversion clock, runs only while waiting
  task automatic wait_done(output int k);
    k = 0;
    cs_n_out = 1'b0;
    while (done_n_in !== 1'b0 && k < 600) begin
      k++;
      if (k % 5 == 0) eclk_out = ~eclk_out;
      cyc(1);
    end
    cs_n_out = 1'b1;
  endtask
endmodule

// ===== tb/sar_ctl_properties.sv
`timescale 1ns/1ps
module sar_ctl_properties (
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       cs_n_in,
  input wire logic       wr_n_in,
  input wire logic       rd_n_in,
  input wire logic       upper_byte_sel_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  input wire logic       done_n_out,
  input wire logic       converting_out,
  input wire logic [1:0] power_mode_out,
  input wire logic       int_clk_sel_out,
  input wire logic       acquire_timing_sel_out,
  input wire logic       input_config_sel_out,
  input wire logic       polarity_sel_out,
  input wire logic [2:0] chan_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_oe_needs_read: assert property (data_oe_out |-> !$past(cs_n_in, 3) && !$past(rd_n_in, 3))
    else $error("bus driven without read");
  a_oe_quiet: assert property (cs_n_in [*4] |-> !data_oe_out)
    else $error("bus driven while deselected");
  a_read_clears_done: assert property ($rose(data_oe_out) |-> done_n_out)
    else $error("flag not released on read");
  a_done_after_conv: assert property ($fell(done_n_out) |-> $past(converting_out))
    else $error("flag fell without conversion");
  a_upper_fill: assert property (upper_byte_sel_in [*6] ##0 data_oe_out |->
    data_out[7:4] == (polarity_sel_out ? 4'h0 : {4{data_out[3]}})) else $error("bad fill");
  a_ctrl_capture: assert property ($rose(wr_n_in) && !cs_n_in |-> ##5
    {power_mode_out, acquire_timing_sel_out, input_config_sel_out, polarity_sel_out,
    chan_addr_out} == $past(data_in, 5)) else $error("control fields not taken");
  a_clk_follows: assert property (power_mode_out[1] |-> int_clk_sel_out == !power_mode_out[0])
    else $error("clock mode mismatch");
  a_clk_keeps: assert property ($changed(power_mode_out) && !power_mode_out[1] |->
    $stable(int_clk_sel_out)) else $error("clock mode lost in power-down");
endmodule

bind sar_adc_parallel_control_port sar_ctl_properties u_props (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .wr_n_in(wr_n_in),
  .rd_n_in(rd_n_in), .upper_byte_sel_in(upper_byte_sel_in), .data_in(data_in),
  .data_out(data_out), .data_oe_out(data_oe_out), .done_n_out(done_n_out),
  .converting_out(converting_out), .power_mode_out(power_mode_out),
  .int_clk_sel_out(int_clk_sel_out), .acquire_timing_sel_out(acquire_timing_sel_out),
  .input_config_sel_out(input_config_sel_out), .polarity_sel_out(polarity_sel_out),
  .chan_addr_out(chan_addr_out));

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clk_in, sys_rst_in, cs_n, wr_n, rd_n, hbe, eclk, oe, done_n, trk, cnv;
  logic        ics, acq, cfg, pol;
  logic [1:0]  pm;
  logic [2:0]  ch;
  logic [7:0]  hd, dout, bus, v;
  logic [11:0] code;
  int          fail_count, tests_run, n;
  logic [7:0]  wb [4] = '{8'hEA, 8'h12, 8'h9D, 8'h67};
  logic        wi [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0]  cb [4] = '{8'h8F, 8'h87, 8'hCF, 8'hC7};
  logic [11:0] cc [4] = '{12'hA5C, 12'hA5C, 12'h3A5, 12'h3A5};
  assign bus = oe ? dout : hd;
  sar_adc_parallel_control_port DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n),
    .wr_n_in(wr_n), .rd_n_in(rd_n), .upper_byte_sel_in(hbe), .ext_conv_clk_in(eclk),
    .data_in(bus), .data_out(dout), .data_oe_out(oe), .sample_code_in(code),
    .done_n_out(done_n), .track_out(trk), .converting_out(cnv), .power_mode_out(pm),
    .int_clk_sel_out(ics), .acquire_timing_sel_out(acq), .input_config_sel_out(cfg),
    .polarity_sel_out(pol), .chan_addr_out(ch));
  host_model host (.clk_in(clk_in), .bus_in(bus), .done_n_in(done_n), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .hbe_out(hbe), .eclk_out(eclk), .d_out(hd));
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic conv_wait(input logic [7:0] b);
    host.wr(b, 1'b1);
    host.wait_done(n);
    `CHK("wait", 1'b1, n < 600)
    if (n >= 600) close_out();
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    code = 12'h000;
    repeat (16) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    host.cyc(3);
    `CHK("reset", 5'h1A, {pm, ics, done_n, oe})
    $display("test reset done");
    foreach (wb[i]) begin
      host.wr(wb[i], 1'b1);
      `CHK("ctrl", {wb[i], wi[i]}, {pm, acq, cfg, pol, ch, ics})
    end
    host.wr(8'h00, 1'b0);
    `CHK("deselected", {8'h67, 1'b1}, {pm, acq, cfg, pol, ch, ics})
    $display("test control done");
    host.wr(8'hC0, 1'b1);
    foreach (cb[i]) begin
      code = cc[i];
      conv_wait(cb[i]);
      `CHK("time", 1'b1, n > 145 && n < 215)
      `CHK("done", 1'b0, done_n)
      host.rd(1'b0, v);
      `CHK("low", cc[i][7:0], v)
      `CHK("clear", 1'b1, done_n)
      host.rd(1'b1, v);
      `CHK("high", {cb[i][3] ? 4'h0 : {4{cc[i][11]}}, cc[i][11:8]}, v)
    end
    $display("test conversion done");
    host.wr(8'h8F, 1'b1);
    host.cyc(60);
    `CHK("busy", 2'h1, {trk, cnv})
    conv_wait(8'h8F);
    `CHK("abort", 1'b1, n > 145)
    host.wr(8'hAF, 1'b1);
    `CHK("write clear", 1'b1, done_n)
    host.cyc(300);
    `CHK("track", 2'h3, {trk, done_n})
    conv_wait(8'h8F);
    `CHK("ext acq time", 1'b1, n > 120 && n < 150)
    `CHK("idle", 2'h0, {trk, cnv})
    $display("test sequence done");
    close_out();
  end
endmodule
